// ===== kpi_keypad.sv
// Keypad pin interrupt block with APB register access and port pin control.
// Function
// - Independent enable bit per port pin.
// - Enabled pin turns its pullup on.
// - Latch request on fall after all high.
// - Edge mode ignores fall while another low.
// - Sense bit picks edge-only or edge-level.
// - Level mode clears after ack and pins high.
// - Vector fetch acknowledges the request.
// - Ack write clears request; reads zero.
// - Falls after ack latch fresh requests.
// - Unmasked request fetches vector at ffe0.
// - Edge mode ack clears request at once.
// - Reset clears request and sense bit.
// - Pending flag shows request, ignores mask.
// - Mask bit blocks processor request when set.
// - Enable forces input; data read needs direction 0.
// - Upper status bits read zero.
// - Reset clears all enable bits.
// - Block works in wait and stop.
module kpi_keypad
  import kpi_pkg::*;
#(
  parameter int PINS = KPI_PINS
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [PINS-1:0] port_pin_n_in,
  output logic      [PINS-1:0] port_pin_n_out,
  output logic      [PINS-1:0] port_pin_n_oe,
  output logic      [PINS-1:0] port_pullup,
  input  wire logic            vector_fetch,
  output logic                 key_irq,
  output logic      [15:0]     key_vector_addr
);

  initial begin
    if (PINS < 1 || PINS > 8) begin
      $error("kpi_keypad: PINS must be 1 to 8");
    end
  end

  logic [PINS-1:0] key_pin_enable_bits;
  logic [PINS-1:0] port_direction;
  logic [PINS-1:0] port_data;
  logic            key_trigger_sense;
  logic            key_request_mask;
  logic            key_pending_flag;
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic            all_high_prev;

  // Bus decode.
  wire access    = psel && penable;
  wire wr        = access && pwrite;
  wire rd        = access && !pwrite;
  wire hit_stat  = (paddr == KPI_OFF_STATUS);
  wire hit_en    = (paddr == KPI_OFF_ENABLE);
  wire hit_dir   = (paddr == KPI_OFF_DIR);
  wire hit_data  = (paddr == KPI_OFF_DATA);
  wire mapped    = hit_stat || hit_en || hit_dir || hit_data;
  wire lane0     = pstrb[0];
  wire wr_stat   = wr && hit_stat && lane0;
  wire wr_en     = wr && hit_en && lane0;
  wire wr_dir    = wr && hit_dir && lane0;
  wire wr_data   = wr && hit_data && lane0;

  // Software acknowledge pulses only on a written one.
  wire sw_ack    = wr_stat && pwdata[KPI_BIT_ACK];
  wire ack       = sw_ack || vector_fetch;

  // Only enabled pins take part; disabled pins count as high.
  wire [PINS-1:0] key_low = ~sync_b & key_pin_enable_bits;
  wire all_high  = (key_low == '0);
  wire fall_evt  = all_prev_high_and_low();
  wire any_low   = !all_high;

  function automatic logic all_prev_high_and_low();
    return all_high_prev && any_low;
  endfunction

  // Edge mode clears at once; level mode also needs every enabled pin high.
  wire clear_ok  = key_trigger_sense ? all_high : 1'b1;
  wire next_flag = fall_evt ? 1'b1 : (ack && clear_ok) ? 1'b0 :
                   (key_pending_flag && !ack) ? 1'b1 :
                   (key_trigger_sense && key_pending_flag && any_low) ? 1'b1 :
                   key_pending_flag && !(ack && clear_ok);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= port_pin_n_in;
      sync_b <= sync_a;
    end
  end

  // Held-low pins after an ack in level mode stay pending via clear_ok;
  // an ack that arrives earlier is remembered so the later high clears.
  logic ack_seen;
  wire next_ack_seen = fall_evt ? 1'b0 : (ack ? 1'b1 : ack_seen);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_pending_flag <= 1'b0;
      ack_seen         <= 1'b0;
      all_high_prev    <= 1'b1;
    end else begin
      all_high_prev    <= all_high;
      ack_seen         <= key_pending_flag ? next_ack_seen : 1'b0;
      if (fall_evt) begin
        key_pending_flag <= 1'b1;
      end else if (key_trigger_sense && key_pending_flag && (ack_seen || ack) && all_high) begin
        key_pending_flag <= 1'b0;
      end else if (!key_trigger_sense && ack) begin
        key_pending_flag <= 1'b0;
      end else begin
        key_pending_flag <= next_flag && key_pending_flag;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_pin_enable_bits <= '0;
      key_trigger_sense   <= 1'b0;
      key_request_mask    <= 1'b0;
      port_direction      <= '0;
      port_data           <= '0;
    end else begin
      if (wr_stat) begin
        key_trigger_sense <= pwdata[KPI_BIT_MODE];
        key_request_mask  <= pwdata[KPI_BIT_MASK];
      end
      if (wr_en) begin
        key_pin_enable_bits <= pwdata[PINS-1:0];
      end
      if (wr_dir) begin
        port_direction <= pwdata[PINS-1:0];
      end
      if (wr_data) begin
        port_data <= pwdata[PINS-1:0];
      end
    end
  end

  // Read path: data register shows pin level only where direction is 0.
  wire [PINS-1:0] data_view = (port_direction & port_data) | (~port_direction & sync_b);
  wire [7:0] stat_view = {4'h0, key_pending_flag, 1'b0,
                          key_request_mask, key_trigger_sense};
  wire [31:0] next_rdata = !rd ? 32'h0000_0000 :
                           hit_stat ? {24'h000000, stat_view} :
                           hit_en ? {{(32-PINS){1'b0}}, key_pin_enable_bits} :
                           hit_dir ? {{(32-PINS){1'b0}}, port_direction} :
                           hit_data ? {{(32-PINS){1'b0}}, data_view} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_rdata;
    end
  end

  // A read returns data one cycle after access starts, so pready waits.
  logic rd_wait;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= rd && !rd_wait;
    end
  end

  assign pready  = !psel || !penable || pwrite || rd_wait;
  assign pslverr = access && pready && !mapped;

  // Enabled pins are forced to inputs and pulled up.
  assign port_pin_n_out  = port_data;
  assign port_pin_n_oe   = port_direction & ~key_pin_enable_bits;
  assign port_pullup     = key_pin_enable_bits;
  // No clock gating: the request works in wait and stop alike.
  assign key_irq         = key_pending_flag && !key_request_mask;
  assign key_vector_addr = KPI_VECTOR_ADDR;

  a_fall_latches: assert property (@(posedge pclk) disable iff (!presetn)
    (all_high_prev && any_low) |=> key_pending_flag)
    else $error("fall after all high did not latch");
  a_edge_ack_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (!key_trigger_sense && ack && !fall_evt) |=> !key_pending_flag)
    else $error("edge mode ack did not clear");
  a_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (key_trigger_sense && key_pending_flag && any_low && !fall_evt) |=> key_pending_flag)
    else $error("level mode cleared while pin low");
  a_no_new_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (!all_high_prev && !key_pending_flag) |=> !key_pending_flag || $past(fall_evt))
    else $error("fall latched while pin low");
  a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    key_irq == (key_pending_flag && !key_request_mask))
    else $error("irq does not follow mask");
  a_pullup_en: assert property (@(posedge pclk) disable iff (!presetn)
    (port_pullup == key_pin_enable_bits) && ((port_pin_n_oe & key_pin_enable_bits) == '0))
    else $error("enabled pin driven or unpulled");
  a_ack_reads0: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit_stat) |=> (prdata[KPI_BIT_ACK] == 1'b0) && (prdata[7:4] == 4'h0))
    else $error("ack or upper bits read nonzero");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    sync_b == $past(sync_a))
    else $error("synchroniser stage skipped");

  c_edge_irq:  cover property (@(posedge pclk) disable iff (!presetn)
    !key_trigger_sense && fall_evt ##1 key_irq);
  c_level_clr: cover property (@(posedge pclk) disable iff (!presetn)
    key_trigger_sense && key_pending_flag && ack && any_low ##[1:20] !key_pending_flag);
  c_vec_fetch: cover property (@(posedge pclk) disable iff (!presetn)
    key_pending_flag && vector_fetch);

endmodule

// ===== kpi_keys_model.sv
// Keypad switches and pin wiring seen by the keypad pin interrupt block.
module kpi_keys_model (
  input  wire logic       pclk,
  input  wire logic [4:0] key_down,
  input  wire logic [4:0] pull_on,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  output logic      [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last = 5'h00;
  always @(posedge pclk) last <= pin;
  // A pin that nobody drives or pulls flips every cycle, so it never looks stable.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin[i] = pin_oe[i] ? pin_out[i] : key_down[i] ? 1'b0 : pull_on[i] ? 1'b1 : ~last[i];
    end
  end
endmodule

// ===== kpi_pkg.sv
// Constants for the keypad pin interrupt block.
package kpi_pkg;
  localparam int          KPI_PINS        = 5;
  localparam logic [11:0] KPI_OFF_STATUS  = 12'h000;
  localparam logic [11:0] KPI_OFF_ENABLE  = 12'h004;
  localparam logic [11:0] KPI_OFF_DIR     = 12'h008;
  localparam logic [11:0] KPI_OFF_DATA    = 12'h00c;
  localparam int          KPI_BIT_MODE    = 0;
  localparam int          KPI_BIT_MASK    = 1;
  localparam int          KPI_BIT_ACK     = 2;
  localparam int          KPI_BIT_FLAG    = 3;
  localparam logic [15:0] KPI_VECTOR_ADDR = 16'hffe0;
  localparam logic [7:0]  KPI_RESET_BYTE  = 8'h00;
endpackage

// ===== tb.sv
// Self-checking bench for the keypad pin interrupt block over APB.
module tb import kpi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, vector_fetch, key_irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [4:0]  pin, pin_out, pin_oe, pull_on, keys;
  logic [15:0] vaddr;
  int          miscompares, tests_run;
  kpi_keypad kpi_keypad_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pin_n_in(pin), .port_pin_n_out(pin_out),
    .port_pin_n_oe(pin_oe), .port_pullup(pull_on), .vector_fetch(vector_fetch),
    .key_irq(key_irq), .key_vector_addr(vaddr));
  kpi_keys_model kpi_keys_model_inst (.pclk(pclk), .key_down(keys), .pull_on(pull_on),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin(pin));
  always #50 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rs(input logic [31:0] exp);
    apb(1'b0, KPI_OFF_STATUS, 32'h0);
    chk("status", exp, rd);
  endtask
  task automatic press(input logic [4:0] v);
    @(posedge pclk);
    keys <= v;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; keys = 0; vector_fetch = 0; miscompares = 0; tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rs(32'h0);
    apb(1'b0, KPI_OFF_ENABLE, 32'h0);
    chk("enable", 32'h0, rd);
    chk("pullup", 32'h0, {27'h0, pull_on});
    wr(KPI_OFF_STATUS, 32'h2);
    wr(KPI_OFF_ENABLE, 32'h1f);
    wr(KPI_OFF_STATUS, 32'h6);
    wr(KPI_OFF_STATUS, 32'h0);
    chk("pullup", 32'h1f, {27'h0, pull_on});
    rs(32'h0);
    $display("test init done");
    press(5'h01);
    chk("irq", 32'h1, {31'h0, key_irq});
    chk("vector", 32'hffe0, {16'h0, vaddr});
    wr(KPI_OFF_STATUS, 32'h4);
    press(5'h03);
    rs(32'h0);
    press(5'h00);
    press(5'h10);
    rs(32'h8);
    @(posedge pclk);
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, key_irq});
    press(5'h00);
    $display("test edge done");
    wr(KPI_OFF_STATUS, 32'h2);
    press(5'h02);
    rs(32'ha);
    chk("irq", 32'h0, {31'h0, key_irq});
    press(5'h00);
    wr(KPI_OFF_STATUS, 32'hf5);
    rs(32'h1);
    press(5'h02);
    rs(32'h9);
    wr(KPI_OFF_STATUS, 32'h5);
    rs(32'h9);
    press(5'h00);
    rs(32'h1);
    press(5'h02);
    $display("test level done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rs(32'h0);
    wr(KPI_OFF_ENABLE, 32'h1f);
    wr(KPI_OFF_DIR, 32'h1f);
    chk("oe", 32'h0, {27'h0, pin_oe});
    wr(KPI_OFF_ENABLE, 32'h0);
    chk("oe", 32'h1f, {27'h0, pin_oe});
    wr(KPI_OFF_DATA, 32'h15);
    chk("pin_out", 32'h15, {27'h0, pin_out});
    apb(1'b0, KPI_OFF_DATA, 32'h0);
    chk("data", 32'h15, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset and port done");
    complete_run();
  end
endmodule
